// ### hdl/cmou_pkg.sv
//------------------------------------------------------------------------------
// Contract
// - force strobe acts like a real match; the code ignores it in pwm waveform modes
// - forced match sets no flag
// - counter write blocks next timer-tick matches
// - counter write equal TOP loses TOP match
// - output state survives waveform mode change
// - output mode field acts immediately
// - mode field picks next state at match
// - nonzero mode field overrides port value
// - reset clears stored output state
// - direction bit still controls pin drive
// - mode field never touches input capture
// - mode-specific port override exceptions applied
// - mode field zero leaves state unchanged
//------------------------------------------------------------------------------
package cmou_pkg;

  //----------------------------------------------------------------------------
  // register map (byte addresses)
  //----------------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] FORCE_OFFSET  = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] MASK_OFFSET   = 8'h0C;
  localparam logic [7:0] STATE_OFFSET  = 8'h10;
  localparam int         ADDR_BITS     = 8;

  //----------------------------------------------------------------------------
  // field positions
  //----------------------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;  // output mode field, 2 bits
  localparam int CTRL_WGM_LSB  = 2;  // waveform select, 4 bits
  localparam int CTRL_DIR_BIT  = 6;  // pin direction bit
  localparam int CTRL_PORT_BIT = 7;  // general i/o output value
  localparam int FORCE_BIT     = 0;
  localparam int EV_MATCH_BIT  = 0;  // compare match flag
  localparam int EV_BLOCK_BIT  = 1;  // match blocked by counter write
  localparam int EV_COUNT      = 2;
  localparam int ST_OUT_BIT    = 0;
  localparam int ST_BLOCK_BIT  = 1;
  localparam int ST_PWM_BIT    = 2;
  localparam int ST_OVR_BIT    = 3;

  //----------------------------------------------------------------------------
  // reset values
  //----------------------------------------------------------------------------
  localparam logic [7:0]          CTRL_RESET   = 8'h00;
  localparam logic [EV_COUNT-1:0] STATUS_RESET = 2'h0;
  localparam logic [EV_COUNT-1:0] MASK_RESET   = 2'h0;
  localparam logic                STATE_RESET  = 1'h0;

  //----------------------------------------------------------------------------
  // output mode field and waveform select codes
  //----------------------------------------------------------------------------
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_TOGGLE = 2'h1;
  localparam logic [1:0] MODE_CLEAR  = 2'h2;
  localparam logic [1:0] MODE_SET    = 2'h3;
  localparam logic [3:0] WGM_NORMAL   = 4'h0;
  localparam logic [3:0] WGM_CTC_CMP  = 4'h4;
  localparam logic [3:0] WGM_CTC_CAP  = 4'hC;
  localparam logic [3:0] WGM_RSVD     = 4'hD;
  localparam logic [3:0] WGM_PFC_CMP  = 4'h9;
  localparam logic [3:0] WGM_PC_CMP   = 4'hB;
  localparam logic [3:0] WGM_FAST_CMP = 4'hF;

  typedef enum logic [1:0] {
    CMOU_NONPWM,
    CMOU_FAST,
    CMOU_PHASE
  } cmou_class_type;

  //----------------------------------------------------------------------------
  // software control word
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic       port_value;
    logic       direction;
    logic [3:0] wgm;
    logic [1:0] mode;
  } cmou_ctrl_type;

  // strobes from the timer core, all on sys_clk
  typedef struct packed {
    logic tick;        // qualified timer clock enable
    logic match;       // raw comparator equality
    logic top;         // counter at TOP
    logic bottom;      // counter at BOTTOM
    logic count_down;  // counting direction
    logic cnt_write;   // processor wrote the counter
  } cmou_timer_type;

endpackage

// ### hdl/cmou_action.sv
`timescale 1ns/1ps
// next stored state and port override for one compare channel
module cmou_action #(
  parameter bit CHANNEL_A = 1'b1
) (
  // control
  input  wire cmou_pkg::cmou_ctrl_type  ctrl,
  input  wire logic                     state,
  // events
  input  wire logic                     match_ev,
  input  wire logic                     force_ev,
  input  wire logic                     bottom_ev,
  input  wire logic                     count_down,
  // results
  output logic                          next_state,
  output logic                          override_en,
  output logic                          pwm_mode
);

  cmou_pkg::cmou_class_type wclass;
  logic                     toggle_ok;

  // classify waveform mode
  always_comb begin
    case (ctrl.wgm)
      4'h0, 4'h4, 4'hC, 4'hD: wclass = cmou_pkg::CMOU_NONPWM;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: wclass = cmou_pkg::CMOU_FAST;
      default: wclass = cmou_pkg::CMOU_PHASE;
    endcase
  end

  assign pwm_mode = (wclass != cmou_pkg::CMOU_NONPWM);

  // in pwm modes toggle exists only on unit a with top from compare
  always_comb begin
    case (wclass)
      cmou_pkg::CMOU_NONPWM: toggle_ok = 1'b1;
      cmou_pkg::CMOU_FAST:   toggle_ok = CHANNEL_A && (ctrl.wgm == cmou_pkg::WGM_FAST_CMP);
      default: toggle_ok = CHANNEL_A && ((ctrl.wgm == cmou_pkg::WGM_PFC_CMP) || (ctrl.wgm == cmou_pkg::WGM_PC_CMP));
    endcase
  end

  // override follows the live field; toggle exceptions fall back to port
  always_comb begin
    if (ctrl.mode == cmou_pkg::MODE_OFF) begin
      override_en = 1'b0;
    end else if (ctrl.mode == cmou_pkg::MODE_TOGGLE) begin
      override_en = toggle_ok;
    end else begin
      override_en = 1'b1;
    end
  end

  // state update; field is read live, never buffered
  always_comb begin
    next_state = state;
    case (wclass)
      cmou_pkg::CMOU_NONPWM: begin
        if (match_ev || force_ev) begin
          case (ctrl.mode)
            cmou_pkg::MODE_TOGGLE: next_state = ~state;
            cmou_pkg::MODE_CLEAR:  next_state = 1'b0;
            cmou_pkg::MODE_SET:    next_state = 1'b1;
            default:               next_state = state;
          endcase
        end
      end
      cmou_pkg::CMOU_FAST: begin
        if (match_ev) begin
          case (ctrl.mode)
            cmou_pkg::MODE_TOGGLE: next_state = toggle_ok ? ~state : state;
            cmou_pkg::MODE_CLEAR:  next_state = 1'b0;
            cmou_pkg::MODE_SET:    next_state = 1'b1;
            default:               next_state = state;
          endcase
        end else if (bottom_ev) begin
          case (ctrl.mode)
            cmou_pkg::MODE_CLEAR: next_state = 1'b1;
            cmou_pkg::MODE_SET:   next_state = 1'b0;
            default:              next_state = state;
          endcase
        end
      end
      default: begin
        if (match_ev) begin
          case (ctrl.mode)
            cmou_pkg::MODE_TOGGLE: next_state = toggle_ok ? ~state : state;
            cmou_pkg::MODE_CLEAR:  next_state = count_down;
            cmou_pkg::MODE_SET:    next_state = ~count_down;
            default:               next_state = state;
          endcase
        end
      end
    endcase
  end

endmodule

// ### hdl/cmou_top.sv
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// compare match output unit with ahb-lite register access
module cmou_top #(
  parameter bit CHANNEL_A = 1'b1
) (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  // ahb-lite slave
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  // timer core strobes
  input  wire cmou_pkg::cmou_timer_type     timer,
  // compare pin
  output logic                              pin_out,
  output logic                              pin_oe,
  // status
  output logic                              compare_match_flag,
  output logic                              irq
);

  //----------------------------------------------------------------------------
  // bus front end
  //----------------------------------------------------------------------------
  logic                              dphase;
  logic                              dp_write;
  logic [cmou_pkg::ADDR_BITS-1:0]    dp_addr;
  logic                              wr_en;
  logic                              rd_done;

  // one wait cycle so read data can come from a flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dphase    <= 1'b0;
      dp_write  <= 1'b0;
      dp_addr   <= '0;
      hreadyout <= 1'b1;
    end else if (dphase) begin
      dphase    <= 1'b0;
      hreadyout <= 1'b1;
    end else if (hsel && htrans[1] && hready) begin
      dphase    <= 1'b1;
      dp_write  <= hwrite;
      dp_addr   <= haddr[cmou_pkg::ADDR_BITS-1:0];
      hreadyout <= 1'b0;
    end
  end

  // the write is applied in the stall cycle, when hwdata is valid
  assign wr_en   = dphase && dp_write;
  assign rd_done = dphase && !dp_write;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;  // always okay; unmapped reads give zero
    end
  end

  //----------------------------------------------------------------------------
  // software registers
  //----------------------------------------------------------------------------
  cmou_pkg::cmou_ctrl_type         ctrl;
  logic [cmou_pkg::EV_COUNT-1:0]   status;
  logic [cmou_pkg::EV_COUNT-1:0]   mask;
  logic                            force_pulse;
  logic                            out_state;
  logic                            block_armed;
  logic                            pwm_mode;
  logic                            override_en;
  logic                            next_state;
  logic                            match_ev;
  logic                            blocked_ev;
  logic                            bottom_ev;
  logic                            force_ev;
  logic [cmou_pkg::EV_COUNT-1:0]   events;
  logic [cmou_pkg::EV_COUNT-1:0]   w1c;

  // control word; mode field takes effect on the next clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl <= cmou_pkg::CTRL_RESET;
    end else if (wr_en && dp_addr == cmou_pkg::CTRL_OFFSET) begin
      ctrl <= hwdata[7:0];
    end
  end

  // interrupt mask
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask <= cmou_pkg::MASK_RESET;
    end else if (wr_en && dp_addr == cmou_pkg::MASK_OFFSET) begin
      mask <= hwdata[cmou_pkg::EV_COUNT-1:0];
    end
  end

  // force strobe lives one cycle only and reads back as zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      force_pulse <= 1'b0;
    end else begin
      force_pulse <= wr_en && (dp_addr == cmou_pkg::FORCE_OFFSET)
                     && hwdata[cmou_pkg::FORCE_BIT];
    end
  end

  //----------------------------------------------------------------------------
  // match qualification
  //----------------------------------------------------------------------------
  // a counter write arms the block; it lasts through the next timer tick,
  // even if that tick is far off because the timer clock is stopped
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      block_armed <= 1'b0;
    end else if (timer.cnt_write) begin
      block_armed <= 1'b1;
    end else if (timer.tick) begin
      block_armed <= 1'b0;
    end
  end

  // a write in the same cycle as a tick still guards the following tick
  assign match_ev   = timer.tick && timer.match && !block_armed;
  assign blocked_ev = timer.tick && timer.match && block_armed;
  assign bottom_ev  = timer.tick && timer.bottom;
  assign force_ev   = force_pulse && !pwm_mode;

  //----------------------------------------------------------------------------
  // waveform action
  //----------------------------------------------------------------------------
  cmou_action #(
    .CHANNEL_A (CHANNEL_A)
  ) u_action (
    .ctrl        (ctrl),
    .state       (out_state),
    .match_ev    (match_ev),
    .force_ev    (force_ev),
    .bottom_ev   (bottom_ev),
    .count_down  (timer.count_down),
    .next_state  (next_state),
    .override_en (override_en),
    .pwm_mode    (pwm_mode)
  );

  // stored output state, independent of mode changes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_state <= cmou_pkg::STATE_RESET;
    end else begin
      out_state <= next_state;
    end
  end

  //----------------------------------------------------------------------------
  // pin drive
  //----------------------------------------------------------------------------
  // pin follows one clock behind the state; direction alone decides drive
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= override_en ? out_state : ctrl.port_value;
      pin_oe  <= ctrl.direction;
    end
  end

  //----------------------------------------------------------------------------
  // events and interrupt
  //----------------------------------------------------------------------------
  // forced matches never reach the flag; only a real qualified match does
  always_comb begin
    events                         = '0;
    events[cmou_pkg::EV_MATCH_BIT] = match_ev;
    events[cmou_pkg::EV_BLOCK_BIT] = blocked_ev;
  end

  assign w1c = (wr_en && dp_addr == cmou_pkg::STATUS_OFFSET)
               ? hwdata[cmou_pkg::EV_COUNT-1:0] : '0;

  // sticky bits; a new event beats a clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status <= cmou_pkg::STATUS_RESET;
    end else begin
      status <= (status & ~w1c) | events;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq                <= 1'b0;
      compare_match_flag <= 1'b0;
    end else begin
      irq                <= |((status & ~w1c | events) & mask);
      compare_match_flag <= (status[cmou_pkg::EV_MATCH_BIT] & ~w1c[cmou_pkg::EV_MATCH_BIT])
                            | events[cmou_pkg::EV_MATCH_BIT];
    end
  end

  //----------------------------------------------------------------------------
  // read data
  //----------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_done) begin
      hrdata <= 32'h0000_0000;
      case (dp_addr)
        cmou_pkg::CTRL_OFFSET:   hrdata[7:0] <= ctrl;
        cmou_pkg::STATUS_OFFSET: hrdata[cmou_pkg::EV_COUNT-1:0] <= status;
        cmou_pkg::MASK_OFFSET:   hrdata[cmou_pkg::EV_COUNT-1:0] <= mask;
        cmou_pkg::STATE_OFFSET: begin
          hrdata[cmou_pkg::ST_OUT_BIT]   <= out_state;
          hrdata[cmou_pkg::ST_BLOCK_BIT] <= block_armed;
          hrdata[cmou_pkg::ST_PWM_BIT]   <= pwm_mode;
          hrdata[cmou_pkg::ST_OVR_BIT]   <= override_en;
        end
        default: hrdata <= 32'h0000_0000;  // force strobe and holes read zero
      endcase
    end
  end

  // the output mode field has no path toward input capture
  // hsize is ignored: only whole-word accesses are expected

endmodule

// ### tb/cmou_pin_model.sv
`timescale 1ns/1ps
//------------------------------------------------------------------------------
// board side of the compare pin: a pull-down holds the net low when undriven
//------------------------------------------------------------------------------
module cmou_pin_model (
  // pin drive from the unit
  input  wire logic pin_out,
  input  wire logic pin_oe,
  // level seen by the external circuit
  output logic      pin_level
);
  // released pin reads the pull-down, never the last driven value
  assign pin_level = pin_oe ? pin_out : 1'b0;
endmodule

// ### tb/cmou_monitor.sv
`timescale 1ns/1ps
//------------------------------------------------------------------------------
// protocol and behaviour checker for the compare output unit
//------------------------------------------------------------------------------
module cmou_monitor (
  // clock and reset
  input wire logic                     sys_clk,
  input wire logic                     rst,
  // ahb-lite slave side
  input wire logic                     hsel,
  input wire logic [31:0]              haddr,
  input wire logic [1:0]               htrans,
  input wire logic                     hwrite,
  input wire logic [31:0]              hwdata,
  input wire logic                     hready,
  input wire logic                     hreadyout,
  input wire logic                     hresp,
  // timer and pin
  input wire cmou_pkg::cmou_timer_type timer,
  input wire logic                     pin_out,
  input wire logic                     pin_oe,
  input wire logic                     compare_match_flag,
  input wire logic                     irq
);
  logic       ph;
  logic       ph_wr;
  logic [7:0] ph_addr;
  logic       armed;
  logic       taken;
  logic       wr_ctrl;
  logic       wr_mask;
  logic       good;

  // data phase tracking, so writes can be tied to their effect
  assign taken   = hsel && htrans[1] && hready;
  assign wr_ctrl = ph && ph_wr && (ph_addr == cmou_pkg::CTRL_OFFSET);
  assign wr_mask = ph && ph_wr && (ph_addr == cmou_pkg::MASK_OFFSET);
  // a write in the tick's cycle guards the next tick
  assign good    = timer.tick && timer.match && !armed;

  // address phase capture
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph      <= 1'b0;
      ph_wr   <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ph <= taken;
      if (taken) begin
        ph_addr <= haddr[7:0];
        ph_wr   <= hwrite;
      end
    end
  end

  // block window: opened by a counter write, closed by the next tick
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (timer.cnt_write) begin
      armed <= 1'b1;
    end else if (timer.tick) begin
      armed <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  reset_clear_a: assert property ($fell(rst) |-> !pin_out && !pin_oe && !irq && !compare_match_flag)
    else $error("outputs not cleared after reset");
  bus_wait_a: assert property (taken |=> !hreadyout ##1 hreadyout)
    else $error("bus transfer did not take one wait state");
  hresp_okay_a: assert property (!hresp)
    else $error("slave response not okay");
  flag_cause_a: assert property ($rose(compare_match_flag) |-> $past(good) || $past(good, 2))
    else $error("match flag rose without an unblocked match");
  match_flag_a: assert property (good |-> ##[1:2] compare_match_flag)
    else $error("unblocked match did not raise the flag");
  oe_direction_a: assert property (wr_ctrl |-> ##2 (pin_oe == $past(hwdata[6], 2)))
    else $error("pin enable does not follow direction bit");
  port_value_a: assert property ((wr_ctrl && hwdata[1:0] == 2'h0) |-> ##2 (pin_out == $past(hwdata[7], 2)))
    else $error("pin value not from port bit with mode field zero");
  mask_quiet_a: assert property ((wr_mask && hwdata[1:0] == 2'h0) |-> ##2 !irq [*2])
    else $error("interrupt high with all events masked");

  match_seen_c: cover property (good);
  block_seen_c: cover property (timer.tick && timer.match && armed);
  irq_seen_c: cover property ($rose(irq));
  drive_seen_c: cover property ($rose(pin_oe));
endmodule

bind cmou_top cmou_monitor u_mon (
  .sys_clk            (sys_clk),
  .rst                (rst),
  .hsel               (hsel),
  .haddr              (haddr),
  .htrans             (htrans),
  .hwrite             (hwrite),
  .hwdata             (hwdata),
  .hready             (hready),
  .hreadyout          (hreadyout),
  .hresp              (hresp),
  .timer              (timer),
  .pin_out            (pin_out),
  .pin_oe             (pin_oe),
  .compare_match_flag (compare_match_flag),
  .irq                (irq)
);

// ### tb/cmou_top_test.sv
`timescale 1ns/1ps
module cmou_top_test;
  localparam cmou_pkg::cmou_timer_type T_MATCH = 6'h30;
  localparam cmou_pkg::cmou_timer_type T_WRITE = 6'h01;
  logic                     sys_clk;
  logic                     rst;
  logic                     hsel;
  logic [31:0]              haddr;
  logic [1:0]               htrans;
  logic                     hwrite;
  logic [2:0]               hsize;
  logic [31:0]              hwdata;
  logic [31:0]              hrdata;
  logic                     hreadyout;
  logic                     hresp;
  cmou_pkg::cmou_timer_type timer;
  logic                     pin_out;
  logic                     pin_oe;
  logic                     flag;
  logic                     irq;
  logic                     pin_level;
  int                       n_mismatch;
  int                       n_compared;
  logic [1:0]               fm [5];
  logic                     fe [5];

  cmou_top DUT (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer(timer), .pin_out(pin_out), .pin_oe(pin_oe), .compare_match_flag(flag), .irq(irq));
  cmou_pin_model PIN (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));

  // 100 MHz system clock
  always #5 sys_clk = ~sys_clk;

  // wait for hready high, sampled with the read data at a falling edge, then step on to the rising edge
  task automatic wait_rdy(output logic [31:0] d);
    logic ok;
    ok = 1'b0;
    while (ok !== 1'b1) begin
      @(negedge sys_clk);
      ok = hreadyout;
      d = hrdata;
      @(posedge sys_clk);
    end
  endtask
  // one single-word transfer: address phase, then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    wait_rdy(d);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? wd : 32'h00000000;
    wait_rdy(d);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    bus(a, 1'b1, v, d);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus(a, 1'b0, 32'h00000000, d);
    chk(nm, e, d);
  endtask
  task automatic rdbit(input string nm, input logic [7:0] a, input int b, input logic e);
    logic [31:0] d;
    bus(a, 1'b0, 32'h00000000, d);
    chk(nm, {31'h00000000, e}, {31'h00000000, d[b]});
  endtask
  // one timer strobe cycle, then quiet
  task automatic tmr(input cmou_pkg::cmou_timer_type t);
    timer <= t;
    @(posedge sys_clk);
    timer <= 6'h00;
    @(posedge sys_clk);
  endtask
  // look at a port mid-cycle, where it is settled
  task automatic port(input string nm, input logic e, ref logic s);
    @(negedge sys_clk);
    chk(nm, {31'h00000000, e}, {31'h00000000, s});
    @(posedge sys_clk);
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [3:0] g, input logic dr, input logic pv);
    return {24'h000000, pv, dr, g, m};
  endfunction
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    $display("watchdog expired");
    close_out;
  end

  initial begin
    sys_clk = 1'b0; rst = 1'b1; hsel = 1'b0; haddr = 32'h00000000; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h00000000; timer = 6'h00; n_mismatch = 0; n_compared = 0;
    fm = '{cmou_pkg::MODE_SET, cmou_pkg::MODE_OFF, cmou_pkg::MODE_CLEAR, cmou_pkg::MODE_TOGGLE, cmou_pkg::MODE_TOGGLE};
    fe = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // reset values, unmapped place
    port("pin_oe", 1'b0, pin_oe);
    rdchk("ctrl", cmou_pkg::CTRL_OFFSET, {24'h000000, cmou_pkg::CTRL_RESET});
    rdchk("status", cmou_pkg::STATUS_OFFSET, {30'h00000000, cmou_pkg::STATUS_RESET});
    rdchk("mask", cmou_pkg::MASK_OFFSET, {30'h00000000, cmou_pkg::MASK_RESET});
    rdchk("state", cmou_pkg::STATE_OFFSET, 32'h00000000);
    wr(8'h14, 32'hFFFFFFFF);
    rdchk("unmapped", 8'h14, 32'h00000000);
    rdchk("ctrl after unmapped", cmou_pkg::CTRL_OFFSET, 32'h00000000);
    $display("test reset done");
    // forced matches through every mode code
    for (int i = 0; i < 5; i++) begin
      wr(cmou_pkg::CTRL_OFFSET, ctl(fm[i], cmou_pkg::WGM_NORMAL, 1'b0, 1'b0));
      wr(cmou_pkg::FORCE_OFFSET, 32'h00000001);
      rdbit("forced state", cmou_pkg::STATE_OFFSET, cmou_pkg::ST_OUT_BIT, fe[i]);
    end
    rdchk("status after force", cmou_pkg::STATUS_OFFSET, 32'h00000000);
    $display("test force done");
    // real matches, mode change acting at once
    wr(cmou_pkg::CTRL_OFFSET, ctl(cmou_pkg::MODE_SET, cmou_pkg::WGM_NORMAL, 1'b0, 1'b0));
    tmr(T_MATCH);
    rdbit("match set", cmou_pkg::STATE_OFFSET, cmou_pkg::ST_OUT_BIT, 1'b1);
    port("flag", 1'b1, flag);
    wr(cmou_pkg::CTRL_OFFSET, ctl(cmou_pkg::MODE_CLEAR, cmou_pkg::WGM_NORMAL, 1'b0, 1'b0));
    tmr(T_MATCH);
    rdbit("match clear", cmou_pkg::STATE_OFFSET, cmou_pkg::ST_OUT_BIT, 1'b0);
    wr(cmou_pkg::STATUS_OFFSET, 32'h00000003);
    rdchk("status cleared", cmou_pkg::STATUS_OFFSET, 32'h00000000);
    $display("test match done");
    // counter write with timer stopped blocks exactly one tick
    wr(cmou_pkg::CTRL_OFFSET, ctl(cmou_pkg::MODE_SET, cmou_pkg::WGM_NORMAL, 1'b0, 1'b0));
    tmr(T_WRITE);
    repeat (3) @(posedge sys_clk);
    tmr(T_MATCH);
    rdbit("blocked state", cmou_pkg::STATE_OFFSET, cmou_pkg::ST_OUT_BIT, 1'b0);
    rdchk("blocked status", cmou_pkg::STATUS_OFFSET, 32'h00000002);
    tmr(T_MATCH);
    rdbit("released state", cmou_pkg::STATE_OFFSET, cmou_pkg::ST_OUT_BIT, 1'b1);
    rdchk("released status", cmou_pkg::STATUS_OFFSET, 32'h00000003);
    $display("test block done");
    // interrupt raised, masked, unmasked, cleared
    wr(cmou_pkg::MASK_OFFSET, 32'h00000001);
    port("irq on", 1'b1, irq);
    wr(cmou_pkg::MASK_OFFSET, 32'h00000000);
    port("irq masked", 1'b0, irq);
    wr(cmou_pkg::MASK_OFFSET, 32'h00000002);
    port("irq block", 1'b1, irq);
    wr(cmou_pkg::STATUS_OFFSET, 32'h00000003);
    port("irq cleared", 1'b0, irq);
    port("flag cleared", 1'b0, flag);
    $display("test irq done");
    // pin source and direction, state set before drive is enabled
    wr(cmou_pkg::CTRL_OFFSET, ctl(cmou_pkg::MODE_OFF, cmou_pkg::WGM_NORMAL, 1'b0, 1'b1));
    port("pin released", 1'b0, pin_level);
    wr(cmou_pkg::CTRL_OFFSET, ctl(cmou_pkg::MODE_OFF, cmou_pkg::WGM_NORMAL, 1'b1, 1'b1));
    port("pin port high", 1'b1, pin_level);
    wr(cmou_pkg::CTRL_OFFSET, ctl(cmou_pkg::MODE_CLEAR, cmou_pkg::WGM_NORMAL, 1'b1, 1'b0));
    port("pin overridden", 1'b1, pin_level);
    wr(cmou_pkg::CTRL_OFFSET, ctl(cmou_pkg::MODE_CLEAR, cmou_pkg::WGM_NORMAL, 1'b0, 1'b0));
    port("pin off again", 1'b0, pin_level);
    $display("test pin done");
    // pwm: state survives mode change, force ignored
    wr(cmou_pkg::CTRL_OFFSET, ctl(cmou_pkg::MODE_CLEAR, cmou_pkg::WGM_FAST_CMP, 1'b0, 1'b0));
    rdbit("state kept", cmou_pkg::STATE_OFFSET, cmou_pkg::ST_OUT_BIT, 1'b1);
    rdbit("pwm flag", cmou_pkg::STATE_OFFSET, cmou_pkg::ST_PWM_BIT, 1'b1);
    wr(cmou_pkg::FORCE_OFFSET, 32'h00000001);
    rdbit("force in pwm", cmou_pkg::STATE_OFFSET, cmou_pkg::ST_OUT_BIT, 1'b1);
    wr(cmou_pkg::CTRL_OFFSET, ctl(cmou_pkg::MODE_CLEAR, cmou_pkg::WGM_NORMAL, 1'b0, 1'b0));
    rdbit("state back", cmou_pkg::STATE_OFFSET, cmou_pkg::ST_OUT_BIT, 1'b1);
    wr(cmou_pkg::FORCE_OFFSET, 32'h00000001);
    rdbit("force normal", cmou_pkg::STATE_OFFSET, cmou_pkg::ST_OUT_BIT, 1'b0);
    $display("test pwm done");
    close_out;
  end
endmodule
